// ===== design/codec_rate_consts.svh
/*
 constants for the codec power, reset, rate and frame-sync divider bank.
 assumes inclusion by the design modules and by the testbench.
*/
`ifndef CODEC_RATE_CONSTS_SVH
`define CODEC_RATE_CONSTS_SVH

// register indices on the plain register port
`define ADDR_POWER_RATE      3'h3
`define ADDR_DIVIDER         3'h4

// power_reset_rate_control fields
`define PWR_SEL_HI           7
`define PWR_SEL_LO           6
`define SOFT_RESET_POS       5
`define OSR_HI               4
`define OSR_LO               3
`define ASYNC_RATE_FACTOR_HI              2
`define ASYNC_RATE_FACTOR_LO              0
`define POWER_RATE_RESET     8'h01

// frame_sync_divider_control fields
`define DIV_SELECT_POS       7
`define DIV_N_HI             6
`define DIV_N_LO             3
`define DIV_P_HI             2
`define DIV_P_LO             0

// divider reset codes: wide 16, four-bit 6, three-bit 8 (code 0)
`define DIV_M_RESET          7'h10
`define DIV_N_RESET          4'h6
`define DIV_P_RESET          3'h0

// frame-sync base factor and update delay in sampling periods
`define FS_BASE_DIV          16
`define UPDATE_PERIODS       2

`endif

// ===== design/codec_rate_pkg.sv
/*
 types for the codec power, reset, rate and divider bank.
 assumes nothing beyond the constants header.
*/
package codec_rate_pkg;

   // power-down selection decode
   typedef enum logic [1:0]
   {
      PWR_FULL_ON   = 2'b00,
      PWR_ADC_DOWN  = 2'b01,
      PWR_DAC_DOWN  = 2'b10,
      PWR_ALL_DOWN  = 2'b11
   } power_mode_t;

   // which half of the divider readback comes next
   typedef enum logic
   {
      READ_NP = 1'b0,
      READ_M  = 1'b1
   } readback_t;

endpackage : codec_rate_pkg

// ===== design/frame_sync_gen.sv
/*
 frame-sync generator: divides the master clock by 16*m*n*p.
 assumes the divisor arrives already decoded and stays steady.
*/
`timescale 1ns/100ps
`include "codec_rate_consts.svh"

module frame_sync_gen
#(
   parameter int DIV_W = 20
)
(
   // clock and reset
   input  wire logic             clock,
   input  wire logic             reset_n,
   // divisor, total master clocks per frame
   input  wire logic [DIV_W-1:0] divisor,
   // one-cycle pulse per frame
   output logic                  frame_pulse
);

   logic [DIV_W-1:0] count;

   initial
   begin
      if (DIV_W < 19)
         $error("frame_sync_gen: divisor width too small");
   end

   // count down; reload at zero so the period equals divisor
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         count <= '0;
      else if (count == '0 || count >= divisor)
         count <= divisor - DIV_W'(1);
      else
         count <= count - DIV_W'(1);
   end

   // registered pulse at each reload
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         frame_pulse <= 1'b0;
      else
         frame_pulse <= (count == '0);
   end

endmodule : frame_sync_gen

// ===== design/codec_power_rate_divider_regs.sv
/*
 power, soft reset, oversampling, rate factor and frame-sync divider
 registers of a voice-band codec, with the frame-sync generator.
 assumes a host on a plain register port in this clock domain.
*/
// Notes on behaviour
// - power select: 00 on, 01 adc down, 10 dac down, 11 all down
// - writing one to bit 5 of power register resets whole device; here the frame-sync generator counter is not reset and keeps counting
// - oversample: x1 gives 512, 10 gives 256, 00 gives 128
// - rate factor codes 1..7 give n 1..7, code 0 gives 8
// - rate factor used only when channel rates differ
// - select low loads n and p; select high loads wide m
// - frame rate is master clock over 16 times m n p
// - wide divider 1..128, code zero means 128
// - four-bit divider 1..16, code zero means 16
// - three-bit divider 1..8, code zero means 8
// - new divider values act after two sampling periods
// - first read gives n and p, next read gives m
// - reset defaults m 16, n 6, p 8
// - p equal to 8 means coarse sampling mode
`timescale 1ns/100ps
`include "codec_rate_consts.svh"

module codec_power_rate_divider_regs
   import codec_rate_pkg::*;
#(
   parameter int DIV_W = 20
)
(
   // clock and reset
   input  wire logic        clock,
   input  wire logic        reset_n,
   // register port
   input  wire logic [2:0]  addr,
   input  wire logic [7:0]  wdata,
   input  wire logic        wr_en,
   input  wire logic        rd_en,
   output logic      [7:0]  rdata,
   // channel rate configuration
   input  wire logic        rates_differ,
   // decoded controls
   output logic             adc_power_down,
   output logic             dac_power_down,
   output logic             device_power_down,
   output logic      [9:0]  dac_oversample_ratio,
   output logic      [3:0]  async_rate_factor,
   output logic             coarse_mode,
   output logic             device_reset_pulse,
   output logic             frame_sync_rate,
   output logic             target_sample_rate
);

   logic [7:0]       power_reset_rate_control;
   logic [6:0]       div_m;
   logic [3:0]       div_n;
   logic [2:0]       div_p;
   logic [6:0]       act_m;
   logic [3:0]       act_n;
   logic [2:0]       act_p;
   logic             pending;
   logic [1:0]       period_count;
   readback_t        read_phase;
   logic             soft_reset;
   logic             frame_pulse;
   logic [DIV_W-1:0] divisor;
   logic [7:0]       m_val;
   logic [4:0]       n_val;
   logic [3:0]       p_val;
   logic [2:0]       rate_count;
   logic [3:0]       n_target;

   initial
   begin
      if (DIV_W < 19)
         $error("codec regs: divisor width too small");
   end

   wire wr_power = wr_en && addr == `ADDR_POWER_RATE;
   wire wr_div   = wr_en && addr == `ADDR_DIVIDER;

   assign soft_reset = wr_power && wdata[`SOFT_RESET_POS];

   // power register; reset bit self-clears since it resets the control, divider and rate-count registers
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         power_reset_rate_control <= `POWER_RATE_RESET;
      else if (soft_reset)
         power_reset_rate_control <= `POWER_RATE_RESET;
      else if (wr_power)
         power_reset_rate_control <= wdata;
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         div_m <= `DIV_M_RESET;
         div_n <= `DIV_N_RESET;
         div_p <= `DIV_P_RESET;
      end
      else if (soft_reset)
      begin
         div_m <= `DIV_M_RESET;
         div_n <= `DIV_N_RESET;
         div_p <= `DIV_P_RESET;
      end
      else if (wr_div && wdata[`DIV_SELECT_POS])
         div_m <= wdata[6:0];
      else if (wr_div)
      begin
         div_n <= wdata[`DIV_N_HI:`DIV_N_LO];
         div_p <= wdata[`DIV_P_HI:`DIV_P_LO];
      end
   end

   // two frame periods before new values act
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pending      <= 1'b0;
         period_count <= 2'h0;
         act_m        <= `DIV_M_RESET;
         act_n        <= `DIV_N_RESET;
         act_p        <= `DIV_P_RESET;
      end
      else if (soft_reset)
      begin
         pending      <= 1'b0;
         period_count <= 2'h0;
         act_m        <= `DIV_M_RESET;
         act_n        <= `DIV_N_RESET;
         act_p        <= `DIV_P_RESET;
      end
      else if (wr_div)
      begin
         // a fresh write restarts the wait
         pending      <= 1'b1;
         period_count <= 2'h0;
      end
      else if (pending && frame_pulse)
      begin
         if (period_count == 2'(`UPDATE_PERIODS - 1))
         begin
            pending <= 1'b0;
            act_m   <= div_m;
            act_n   <= div_n;
            act_p   <= div_p;
         end
         period_count <= period_count + 2'h1;
      end
   end

   always_comb
   begin
      m_val = (act_m == 7'h00) ? 8'h80 : {1'b0, act_m};
      n_val = (act_n == 4'h0) ? 5'h10 : {1'b0, act_n};
      p_val = (act_p == 3'h0) ? 4'h8 : {1'b0, act_p};
   end

   assign divisor = DIV_W'(`FS_BASE_DIV) * DIV_W'(m_val)
                    * DIV_W'(n_val) * DIV_W'(p_val);

   frame_sync_gen #(.DIV_W(DIV_W)) u_fsgen
   (
      .clock       (clock),
      .reset_n     (reset_n),
      .divisor     (divisor),
      .frame_pulse (frame_pulse)
   );

   always_comb
   begin
      n_target = (power_reset_rate_control[`ASYNC_RATE_FACTOR_HI:`ASYNC_RATE_FACTOR_LO] == 3'h0)
                 ? 4'h8
                 : {1'b0, power_reset_rate_control[`ASYNC_RATE_FACTOR_HI:`ASYNC_RATE_FACTOR_LO]};
      if (!rates_differ)
         n_target = 4'h1;
   end

   // divide frame pulses by n for the target sample strobe
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         rate_count <= 3'h0;
      else if (soft_reset)
         rate_count <= 3'h0;
      else if (frame_pulse)
         rate_count <= (4'(rate_count) + 4'h1 >= n_target)
                       ? 3'h0 : rate_count + 3'h1;
   end

   // registered strobes
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         frame_sync_rate    <= 1'b0;
         target_sample_rate <= 1'b0;
         device_reset_pulse <= 1'b0;
      end
      else
      begin
         frame_sync_rate    <= frame_pulse;
         target_sample_rate <= frame_pulse && rate_count == 3'h0;
         device_reset_pulse <= soft_reset;
      end
   end

   // coarse mode on p of 8
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         adc_power_down       <= 1'b0;
         dac_power_down       <= 1'b0;
         device_power_down    <= 1'b0;
         dac_oversample_ratio <= 10'h080;
         async_rate_factor    <= 4'h1;
         coarse_mode          <= 1'b1;
      end
      else
      begin
         unique case (power_mode_t'(power_reset_rate_control[7:6]))
            PWR_FULL_ON:
            begin
               adc_power_down    <= 1'b0;
               dac_power_down    <= 1'b0;
               device_power_down <= 1'b0;
            end
            PWR_ADC_DOWN:
            begin
               adc_power_down    <= 1'b1;
               dac_power_down    <= 1'b0;
               device_power_down <= 1'b0;
            end
            PWR_DAC_DOWN:
            begin
               adc_power_down    <= 1'b0;
               dac_power_down    <= 1'b1;
               device_power_down <= 1'b0;
            end
            PWR_ALL_DOWN:
            begin
               adc_power_down    <= 1'b1;
               dac_power_down    <= 1'b1;
               device_power_down <= 1'b1;
            end
         endcase
         if (power_reset_rate_control[`OSR_LO])
            dac_oversample_ratio <= 10'h200;
         else if (power_reset_rate_control[`OSR_HI])
            dac_oversample_ratio <= 10'h100;
         else
            dac_oversample_ratio <= 10'h080;
         async_rate_factor <= n_target;
         coarse_mode       <= (act_p == 3'h0);
      end
   end

   // alternating readback; divider writes and soft reset restart the pair
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         read_phase <= READ_NP;
      else if (soft_reset || wr_div)
         read_phase <= READ_NP;
      else if (rd_en && addr == `ADDR_DIVIDER)
         read_phase <= (read_phase == READ_NP) ? READ_M : READ_NP;
   end

   // read data one cycle later; unmapped reads zero
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         rdata <= 8'h00;
      else if (rd_en && addr == `ADDR_POWER_RATE)
         rdata <= power_reset_rate_control;
      else if (rd_en && addr == `ADDR_DIVIDER && read_phase == READ_NP)
         rdata <= {1'b0, div_n, div_p};
      else if (rd_en && addr == `ADDR_DIVIDER)
         rdata <= {1'b1, div_m};
      else
         rdata <= 8'h00;
   end

   // first readback after reset is the n/p half
   a_read_np_half: assert property (@(posedge clock) disable iff (!reset_n)
      rd_en && addr == `ADDR_DIVIDER && read_phase == READ_NP
      |=> rdata[7] == 1'b0)
      else $error("divider readback half wrong");

   a_coarse_tracks_p: assert property (@(posedge clock) disable iff (!reset_n)
      (act_p == 3'h0) |=> coarse_mode)
      else $error("coarse mode not set for p of 8");

   a_soft_reset_m: assert property (@(posedge clock) disable iff (!reset_n)
      soft_reset |=> div_m == `DIV_M_RESET && div_p == `DIV_P_RESET)
      else $error("soft reset did not restore dividers");

   a_no_early_act: assert property (@(posedge clock) disable iff (!reset_n)
      wr_div && !soft_reset |=> $stable(act_m) [*1])
      else $error("divider took effect immediately");

   a_m_select_keep: assert property (@(posedge clock) disable iff (!reset_n)
      wr_div && wdata[7] && !soft_reset |=> $stable(div_n))
      else $error("m write disturbed n");

   a_power_all: assert property (@(posedge clock) disable iff (!reset_n)
      power_reset_rate_control[7:6] == 2'b11 |=> device_power_down)
      else $error("full power down not decoded");

   a_osr_512: assert property (@(posedge clock) disable iff (!reset_n)
      power_reset_rate_control[3] |=> dac_oversample_ratio == 10'h200)
      else $error("oversample 512 not decoded");

   a_rate_same: assert property (@(posedge clock) disable iff (!reset_n)
      !rates_differ |=> async_rate_factor == 4'h1)
      else $error("rate factor applied with equal rates");

endmodule : codec_power_rate_divider_regs

// ===== test/codec_power_rate_divider_regs_tb.sv
/*
 self-checking bench for the codec power, rate and divider registers.
 assumes the constants header and the design package are compiled first.
*/
`timescale 1ns/100ps
`include "codec_rate_consts.svh"

module codec_power_rate_divider_regs_tb;

   logic       clock;
   logic       reset_n;
   logic [2:0] addr;
   logic [7:0] wdata;
   logic       wr_en;
   logic       rd_en;
   logic [7:0] rdata;
   logic       rates_differ;
   logic       adc_power_down;
   logic       dac_power_down;
   logic       device_power_down;
   logic [9:0] dac_oversample_ratio;
   logic [3:0] async_rate_factor;
   logic       coarse_mode;
   logic       device_reset_pulse;
   logic       frame_sync_rate;
   logic       target_sample_rate;
   int         errors;
   int         cmp_count;

   codec_power_rate_divider_regs u_dut
   (
      .clock                (clock),
      .reset_n              (reset_n),
      .addr                 (addr),
      .wdata                (wdata),
      .wr_en                (wr_en),
      .rd_en                (rd_en),
      .rdata                (rdata),
      .rates_differ         (rates_differ),
      .adc_power_down       (adc_power_down),
      .dac_power_down       (dac_power_down),
      .device_power_down    (device_power_down),
      .dac_oversample_ratio (dac_oversample_ratio),
      .async_rate_factor    (async_rate_factor),
      .coarse_mode          (coarse_mode),
      .device_reset_pulse   (device_reset_pulse),
      .frame_sync_rate      (frame_sync_rate),
      .target_sample_rate   (target_sample_rate)
   );

   // free-running 100 MHz clock
   always #5 clock = ~clock;

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : print_verdict

   task automatic chk(input string name, input logic [15:0] exp,
                      input logic [15:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // one-cycle write strobe, released after the sampling edge
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clock);
      addr  <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clock);
      wr_en <= 1'b0;
   endtask : wr

   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clock);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge clock);
      rd_en <= 1'b0;
      #1 d = rdata;
   endtask : rd

   // cycles up to the next frame pulse, bounded against a hang
   task automatic frame_gap(output int n);
      n = 0;
      do
      begin
         @(posedge clock);
         #1 n++;
      end
      while (frame_sync_rate !== 1'b1 && n < 20000);
      if (n >= 20000)
      begin
         errors++;
         $display("[FAIL] frame pulse expected 1 seen none");
         print_verdict();
      end
   endtask : frame_gap

   task automatic check_defaults;
      logic [7:0] d;
      int         g;
      chk("osr", 16'd128, dac_oversample_ratio);
      chk("coarse", 16'd1, coarse_mode);
      rd(3'h3, d);
      chk("power reg", 16'h01, d);
      rd(3'h4, d);
      chk("np read", 16'h30, d);
      rd(3'h4, d);
      chk("m read", 16'h90, d);
      frame_gap(g);
      frame_gap(g);
      chk("default frame", 16'd12288, g[15:0]);
   endtask : check_defaults

   task automatic check_power;
      for (int i = 0; i < 4; i++)
      begin
         wr(3'h3, {i[1:0], 6'h01});
         repeat (2) @(posedge clock);
         #1 chk("adc down", i[0], adc_power_down);
         chk("dac down", i[1], dac_power_down);
         chk("dev down", i == 3, device_power_down);
      end
   endtask : check_power

   task automatic check_rates;
      logic [2:0] c;
      rates_differ <= 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         c = i[2:0];
         wr(3'h3, {3'b000, c[1:0], c});
         repeat (2) @(posedge clock);
         #1 chk("osr", c[0] ? 512 : c[1] ? 256 : 128,
                dac_oversample_ratio);
         chk("rate n", i == 0 ? 8 : i, async_rate_factor);
      end
      rates_differ <= 1'b0;
      repeat (2) @(posedge clock);
      #1 chk("rate same", 16'd1, async_rate_factor);
   endtask : check_rates

   // target strobe every n frames once the channel rates differ
   task automatic check_target;
      int n;
      wr(3'h3, 8'h03);
      rates_differ <= 1'b1;
      // first pass aligns to a strobe, the later ones measure the gap
      for (int k = 0; k < 3; k++)
      begin
         n = 0;
         do
         begin
            @(posedge clock);
            #1 n++;
         end
         while (target_sample_rate !== 1'b1 && n < 200);
      end
      chk("target gap", 16'd48, n[15:0]);
      if (n >= 200)
         print_verdict();
      @(posedge clock);
      rates_differ <= 1'b0;
   endtask : check_target

   task automatic check_dividers;
      logic [6:0] mc[4] = '{7'h01, 7'h01, 7'h02, 7'h00};
      logic [3:0] nc[4] = '{4'h1, 4'h1, 4'h0, 4'h1};
      logic [2:0] pc[4] = '{3'h1, 3'h0, 3'h1, 3'h1};
      int         per[4] = '{16, 128, 512, 2048};
      logic [7:0] d;
      int         g;
      for (int i = 0; i < 4; i++)
      begin
         wr(3'h4, {1'b1, mc[i]});
         wr(3'h4, {1'b0, nc[i], pc[i]});
         rd(3'h4, d);
         chk("np read", {1'b0, nc[i], pc[i]}, d);
         rd(3'h4, d);
         chk("m read", {1'b1, mc[i]}, d);
         // new values only act after two frames
         repeat (3) frame_gap(g);
         frame_gap(g);
         chk("frame period", per[i], g[15:0]);
         chk("coarse", pc[i] == 3'h0, coarse_mode);
         // 16-cycle frames keep the strobe check short
         if (i == 0)
            check_target();
      end
   endtask : check_dividers

   task automatic check_soft_reset;
      logic [7:0] d;
      int         n;
      wr(3'h3, 8'hE7);
      // the pulse launches on the edge wr returns at; look once it settles
      #1;
      n = 0;
      while (device_reset_pulse !== 1'b1 && n < 4)
      begin
         @(posedge clock);
         #1 n++;
      end
      chk("reset pulse", 16'd1, device_reset_pulse);
      if (n >= 4)
         print_verdict();
      @(posedge clock);
      #1 chk("reset pulse end", 16'd0, device_reset_pulse);
      rd(3'h3, d);
      chk("power reg", 16'h01, d);
      rd(3'h4, d);
      chk("np read", 16'h30, d);
      rd(3'h4, d);
      chk("m read", 16'h90, d);
   endtask : check_soft_reset

   task automatic check_unmapped;
      logic [7:0] d;
      wr(3'h7, 8'hFF);
      rd(3'h7, d);
      chk("unmapped", 16'h00, d);
      @(posedge clock);
      #1 chk("rdata idle", 16'h00, rdata);
      rd(3'h3, d);
      chk("power kept", 16'h01, d);
   endtask : check_unmapped

   // main sequence: every input defined at time zero
   initial
   begin
      clock        = 1'b0;
      reset_n      = 1'b0;
      addr         = 3'h0;
      wdata        = 8'h00;
      wr_en        = 1'b0;
      rd_en        = 1'b0;
      rates_differ = 1'b0;
      errors       = 0;
      cmp_count    = 0;
      repeat (20) @(posedge clock);
      reset_n <= 1'b1;
      @(posedge clock);
      #1 check_defaults();
      check_power();
      check_rates();
      check_dividers();
      check_soft_reset();
      check_unmapped();
      print_verdict();
   end

endmodule : codec_power_rate_divider_regs_tb
